/* logic/hnfc_defs.svh */
/*
  constants for the hdlc nrzi frame codec: flag pattern, crc, timing
  assumes inclusion by bare name from the crc and codec design modules
*/
`ifndef HNFC_DEFS_SVH
`define HNFC_DEFS_SVH
`define HNFC_FLAG        8'h7e
`define HNFC_CRC_POLY    16'h8408
`define HNFC_CRC_PRESET  16'hffff
`define HNFC_CRC_GOOD    16'hf0b8
`define HNFC_MAX_ONES    3'd5
`define HNFC_MIN_ADDR    14
`define HNFC_MAX_ADDR    70
`define HNFC_MIN_LEN     17
`define HNFC_MAX_LEN     400
`define HNFC_CLK_HZ      20000000
`define HNFC_BAUD        1200
`define HNFC_PID_NONE    8'hf0
`define HNFC_SEQ_MOD     8
`endif

/* logic/hnfc_pkg.sv */
/*
  types for the hdlc nrzi frame codec
  assumes hnfc_defs.svh is available on the include path
*/
package hnfc_pkg;
  typedef enum logic [4:0] {
    HNFC_TX_IDLE = 5'b0_0001,
    HNFC_TX_FLAG = 5'b0_0010,
    HNFC_TX_DATA = 5'b0_0100,
    HNFC_TX_FCS  = 5'b0_1000,
    HNFC_TX_END  = 5'b1_0000
  } hnfc_tx_state_t;
endpackage

/* logic/hnfc_crc16.sv */
/*
  one-bit serial crc-ccitt update, lsb-first reflected form
  assumes caller holds the register and feeds one bit per step
*/
`timescale 1ns/100ps
`include "hnfc_defs.svh"
module hnfc_crc16 (
  input  wire logic [15:0] crc_in,
  input  wire logic        bit_in,
  output logic      [15:0] crc_out
);
  always_comb begin
    if (crc_in[0] ^ bit_in) begin
      crc_out = (crc_in >> 1) ^ `HNFC_CRC_POLY;
    end else begin
      crc_out = crc_in >> 1;
    end
  end
endmodule

/* logic/hnfc_codec.sv */
/*
  hdlc frame transmitter and receiver with nrzi line coding
  assumes a single 20 MHz clock; host stream signals synchronous to it
*/
//
// Summary of operation
// - frames open and close with flag 01111110
// - never more than five ones outside flags
// - address field holds 14 to 70 bytes
// - control byte: frame type, 3-bit sequence fields
// - frames may end right after control byte
// - transmitter appends 16-bit check before closing flag
// - receiver flags frames whose check mismatches on rx_bad
// - only address, control, data reach software
// - nrzi: zero toggles line, one holds
// - line toggles at least every seven bits, except in unkeyed idle where it holds
// - receive clock recovered from line transitions
// - bytes sent least significant bit first
// - keyed idle transmitter sends continuous flags
// - sequence numbers count modulo 8
`timescale 1ns/100ps
`include "hnfc_defs.svh"
module hnfc_codec #(
  parameter int BIT_DIV = `HNFC_CLK_HZ / `HNFC_BAUD
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       tx_key,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic            tx_line,
  input  wire logic       rx_line,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_end,
  output logic            rx_good,
  output logic            rx_bad
);
  localparam int DW = $clog2(BIT_DIV + 1);
  localparam logic [DW-1:0] DIV_TOP = DW'(BIT_DIV - 1);
  localparam logic [DW-1:0] DIV_MID = DW'(BIT_DIV / 2);
  // ****************************************
  // transmitter
  // ****************************************
  hnfc_pkg::hnfc_tx_state_t tx_st, next_tx_st;
  logic [DW-1:0] tx_div, next_tx_div;
  logic [7:0]    tx_sh, next_tx_sh;
  logic [3:0]    tx_cnt, next_tx_cnt;
  logic [2:0]    tx_ones, next_tx_ones;
  logic [15:0]   tx_crc, next_tx_crc, tx_crc_upd;
  logic          tx_lastb, next_tx_lastb;
  logic          next_tx_line, tx_tick, tx_bit, tx_stuff;
  assign tx_tick  = (tx_div == DIV_TOP);
  assign tx_bit   = tx_sh[0];
  // end state at bit 0 still owes a stuffed zero after the last check bits
  assign tx_stuff = (tx_st == hnfc_pkg::HNFC_TX_DATA || tx_st == hnfc_pkg::HNFC_TX_FCS ||
                     (tx_st == hnfc_pkg::HNFC_TX_END && tx_cnt == 4'd0))
                    && tx_ones == `HNFC_MAX_ONES;
  hnfc_crc16 u_tx_crc (
    .crc_in  (tx_crc),
    .bit_in  (tx_bit),
    .crc_out (tx_crc_upd)
  );
  assign tx_ready = tx_tick && tx_cnt == 4'd7 && !tx_stuff && tx_valid &&
                    (tx_st == hnfc_pkg::HNFC_TX_FLAG || tx_st == hnfc_pkg::HNFC_TX_DATA)
                    && !tx_lastb;
  always_comb begin
    next_tx_st    = tx_st;
    next_tx_div   = tx_tick ? '0 : DW'(tx_div + 1'b1);
    next_tx_sh    = tx_sh;
    next_tx_cnt   = tx_cnt;
    next_tx_ones  = tx_ones;
    next_tx_crc   = tx_crc;
    next_tx_lastb = tx_lastb;
    next_tx_line  = tx_line;
    if (tx_st == hnfc_pkg::HNFC_TX_IDLE) begin
      next_tx_div = '0;
      if (tx_key) begin
        next_tx_st  = hnfc_pkg::HNFC_TX_FLAG;
        next_tx_sh  = `HNFC_FLAG;
        next_tx_cnt = 4'd0;
      end
    end else if (tx_tick) begin
      if (tx_stuff) begin
        next_tx_line = ~tx_line;
        next_tx_ones = 3'd0;
      end else begin
        next_tx_line = tx_bit ? tx_line : ~tx_line;
        next_tx_sh   = {1'b0, tx_sh[7:1]};
        next_tx_cnt  = 4'(tx_cnt + 1'b1);
        if (tx_st == hnfc_pkg::HNFC_TX_DATA) begin
          next_tx_crc = tx_crc_upd;
        end
        if (tx_st == hnfc_pkg::HNFC_TX_DATA || tx_st == hnfc_pkg::HNFC_TX_FCS) begin
          next_tx_ones = tx_bit ? 3'(tx_ones + 1'b1) : 3'd0;
        end
        if ((tx_cnt == 4'd7 && tx_st != hnfc_pkg::HNFC_TX_FCS) ||
            (tx_st == hnfc_pkg::HNFC_TX_FCS && tx_cnt == 4'd15)) begin
          next_tx_cnt = 4'd0;
          case (tx_st)
            hnfc_pkg::HNFC_TX_FLAG, hnfc_pkg::HNFC_TX_DATA: begin
              if (tx_ready) begin
                next_tx_st    = hnfc_pkg::HNFC_TX_DATA;
                next_tx_sh    = tx_data;
                next_tx_lastb = tx_last;
                if (tx_st == hnfc_pkg::HNFC_TX_FLAG) begin
                  next_tx_crc  = `HNFC_CRC_PRESET;
                  next_tx_ones = 3'd0;
                end
              end else if (tx_st == hnfc_pkg::HNFC_TX_DATA && tx_lastb) begin
                next_tx_st  = hnfc_pkg::HNFC_TX_FCS;
                next_tx_sh  = ~tx_crc_upd[7:0];
              end else if (tx_st == hnfc_pkg::HNFC_TX_FLAG && !tx_key) begin
                next_tx_st = hnfc_pkg::HNFC_TX_IDLE;
              end else begin
                next_tx_st = hnfc_pkg::HNFC_TX_FLAG;
                next_tx_sh = `HNFC_FLAG;
              end
            end
            hnfc_pkg::HNFC_TX_FCS: begin
              next_tx_st    = hnfc_pkg::HNFC_TX_END;
              next_tx_sh    = `HNFC_FLAG;
              next_tx_lastb = 1'b0;
            end
            hnfc_pkg::HNFC_TX_END: begin
              next_tx_st = hnfc_pkg::HNFC_TX_FLAG;
              next_tx_sh = `HNFC_FLAG;
            end
            default: next_tx_st = hnfc_pkg::HNFC_TX_IDLE;
          endcase
        end else if (tx_st == hnfc_pkg::HNFC_TX_FCS && tx_cnt == 4'd7) begin
          next_tx_sh = ~tx_crc[15:8];
        end
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_st    <= hnfc_pkg::HNFC_TX_IDLE;
      tx_div   <= '0;
      tx_sh    <= 8'h00;
      tx_cnt   <= 4'h0;
      tx_ones  <= 3'd0;
      tx_crc   <= `HNFC_CRC_PRESET;
      tx_lastb <= 1'b0;
      tx_line  <= 1'b0;
    end else begin
      tx_st    <= next_tx_st;
      tx_div   <= next_tx_div;
      tx_sh    <= next_tx_sh;
      tx_cnt   <= next_tx_cnt;
      tx_ones  <= next_tx_ones;
      tx_crc   <= next_tx_crc;
      tx_lastb <= next_tx_lastb;
      tx_line  <= next_tx_line;
    end
  end
  // ****************************************
  // receiver
  // ****************************************
  logic [DW-1:0] rx_div, next_rx_div;
  logic          rx_prev, rx_tick, rx_dbit, rx_last;
  logic [7:0]    rx_pat, next_rx_pat, rx_sh, next_rx_sh;
  logic [2:0]    rx_cnt, next_rx_cnt;
  logic [15:0]   rx_crc, next_rx_crc, rx_crc_upd, rx_crc2, next_rx_crc2;
  logic [8:0]    rx_len, next_rx_len;
  logic          rx_in, next_rx_in;
  logic [7:0]    rx_hold, next_rx_hold, rx_hold2, next_rx_hold2;
  logic [1:0]    rx_hcnt, next_rx_hcnt;
  logic [7:0]    next_rx_data;
  logic          next_rx_valid, next_rx_end, next_rx_good, next_rx_bad;
  logic          rx_flag, rx_abort, rx_stuffed;
  assign rx_tick = (rx_div == DIV_MID);
  assign rx_dbit = (rx_line == rx_prev);
  assign rx_flag  = ({rx_dbit, rx_pat[7:1]} == `HNFC_FLAG);
  assign rx_abort = ({rx_dbit, rx_pat[7:1]} == 8'hfe) || ({rx_dbit, rx_pat[7:1]} == 8'hff);
  assign rx_stuffed = (rx_pat[7:3] == 5'b1_1111) && !rx_dbit;
  hnfc_crc16 u_rx_crc (
    .crc_in  (rx_crc),
    .bit_in  (rx_dbit),
    .crc_out (rx_crc_upd)
  );
  always_comb begin
    next_rx_div   = (rx_line != rx_last) ? '0 : (rx_div == DIV_TOP ? '0 : DW'(rx_div + 1'b1));
    next_rx_crc2  = rx_crc2;
    next_rx_pat   = rx_pat;
    next_rx_sh    = rx_sh;
    next_rx_cnt   = rx_cnt;
    next_rx_crc   = rx_crc;
    next_rx_len   = rx_len;
    next_rx_in    = rx_in;
    next_rx_hold  = rx_hold;
    next_rx_hold2 = rx_hold2;
    next_rx_hcnt  = rx_hcnt;
    next_rx_data  = rx_data;
    next_rx_valid = 1'b0;
    next_rx_end   = 1'b0;
    next_rx_good  = 1'b0;
    next_rx_bad   = 1'b0;
    if (rx_tick) begin
      next_rx_pat = {rx_dbit, rx_pat[7:1]};
      if (rx_flag || rx_abort) begin
        if (rx_in && rx_hcnt == 2'd2 && rx_len != 9'd0) begin
          next_rx_end = 1'b1;
          // residue taken at the last byte boundary; flag bits excluded
          if (rx_crc2 == `HNFC_CRC_GOOD && rx_len >= 9'(`HNFC_MIN_LEN) && rx_cnt == 3'd7 && rx_flag)
            next_rx_good = 1'b1;
          else
            next_rx_bad = 1'b1;
        end
        next_rx_in   = rx_flag;
        next_rx_cnt  = 3'd0;
        next_rx_len  = 9'd0;
        next_rx_hcnt = 2'd0;
        next_rx_crc  = `HNFC_CRC_PRESET;
        next_rx_crc2 = `HNFC_CRC_PRESET;
      end else if (rx_in && !rx_stuffed) begin
        next_rx_sh  = {rx_dbit, rx_sh[7:1]};
        next_rx_cnt = 3'(rx_cnt + 1'b1);
        if (rx_cnt == 3'd7) begin
          // two-byte delay keeps check bytes away from software
          next_rx_hold2 = {rx_dbit, rx_sh[7:1]};
          next_rx_hold  = rx_hold2;
          next_rx_crc2  = rx_crc_upd;
          if (rx_hcnt == 2'd2) begin
            next_rx_data  = rx_hold;
            next_rx_valid = 1'b1;
          end else begin
            next_rx_hcnt = 2'(rx_hcnt + 1'b1);
          end
          if (rx_len != 9'(`HNFC_MAX_LEN)) next_rx_len = 9'(rx_len + 1'b1);
        end
      end
      if (rx_in && !rx_flag && !rx_abort && !rx_stuffed) begin
        next_rx_crc = rx_crc_upd;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_div   <= '0;
      rx_prev  <= 1'b0;
      rx_last  <= 1'b0;
      rx_crc2  <= `HNFC_CRC_PRESET;
      rx_pat   <= 8'h00;
      rx_sh    <= 8'h00;
      rx_cnt   <= 3'd0;
      rx_crc   <= `HNFC_CRC_PRESET;
      rx_len   <= 9'd0;
      rx_in    <= 1'b0;
      rx_hold  <= 8'h00;
      rx_hold2 <= 8'h00;
      rx_hcnt  <= 2'd0;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
      rx_end   <= 1'b0;
      rx_good  <= 1'b0;
      rx_bad   <= 1'b0;
    end else begin
      rx_div   <= next_rx_div;
      rx_prev  <= rx_tick ? rx_line : rx_prev;
      rx_last  <= rx_line;
      rx_crc2  <= next_rx_crc2;
      rx_pat   <= next_rx_pat;
      rx_sh    <= next_rx_sh;
      rx_cnt   <= next_rx_cnt;
      rx_crc   <= next_rx_crc;
      rx_len   <= next_rx_len;
      rx_in    <= next_rx_in;
      rx_hold  <= next_rx_hold;
      rx_hold2 <= next_rx_hold2;
      rx_hcnt  <= next_rx_hcnt;
      rx_data  <= next_rx_data;
      rx_valid <= next_rx_valid;
      rx_end   <= next_rx_end;
      rx_good  <= next_rx_good;
      rx_bad   <= next_rx_bad;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  sequence s_bit_gap;
    tx_tick ##1 (!tx_tick) [*2];
  endsequence
  property p_idle_unkeyed;
    @(posedge ref_clk) disable iff (rst)
      (tx_st == hnfc_pkg::HNFC_TX_IDLE && !tx_key) |=> $stable(tx_line);
  endproperty
  a_idle_unkeyed: assert property (p_idle_unkeyed) else $error("line moved while idle");
  property p_stuff_toggles;
    @(posedge ref_clk) disable iff (rst)
      (tx_tick && tx_stuff) |=> (tx_line != $past(tx_line));
  endproperty
  a_stuff_toggles: assert property (p_stuff_toggles) else $error("stuffed zero missing");
  property p_ones_bound;
    @(posedge ref_clk) disable iff (rst) tx_ones <= `HNFC_MAX_ONES;
  endproperty
  a_ones_bound: assert property (p_ones_bound) else $error("too many ones");
  property p_nrzi_one;
    @(posedge ref_clk) disable iff (rst)
      (tx_tick && !tx_stuff && tx_bit && tx_st != hnfc_pkg::HNFC_TX_IDLE) |=> $stable(tx_line);
  endproperty
  a_nrzi_one: assert property (p_nrzi_one) else $error("one bit toggled line");
  property p_ready_tick;
    @(posedge ref_clk) disable iff (rst) tx_ready |-> s_bit_gap;
  endproperty
  a_ready_tick: assert property (p_ready_tick) else $error("ready off bit boundary");
  property p_good_bad;
    @(posedge ref_clk) disable iff (rst) rx_end |-> (rx_good ^ rx_bad);
  endproperty
  a_good_bad: assert property (p_good_bad) else $error("frame verdict wrong");
  property p_fcs_end;
    @(posedge ref_clk) disable iff (rst)
      (tx_st == hnfc_pkg::HNFC_TX_FCS) ##1 (tx_st != hnfc_pkg::HNFC_TX_FCS)
        |-> (tx_st == hnfc_pkg::HNFC_TX_END);
  endproperty
  a_fcs_end: assert property (p_fcs_end) else $error("flag not after check");
  property p_valid_pulse;
    @(posedge ref_clk) disable iff (rst) rx_valid |=> !rx_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("byte strobe too long");
endmodule

/* testbench/hnfc_far_station.sv */
/*
  remote station model: sends nrzi frames to the codec, decodes its line
  assumes one bit lasts DIV clock cycles on both lines
*/
`timescale 1ns/100ps
module hnfc_far_station #(
  parameter int DIV = 8
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic tx_line,
  output logic      rx_line
);
  // ************
  // line model
  // ************
  logic [7:0] q[$];
  logic [7:0] got[$];
  logic [7:0] sh;
  logic       crc_ok;
  logic       lv;
  logic       pl;
  logic       lvl;
  int         ph;
  int         nb;
  int         run;
  int         ones = 7;
  int         frames = 0;
  int         flags = 0;

  function automatic logic [15:0] crc_of(input logic [7:0] d[$]);
    logic [15:0] c = 16'hffff;
    foreach (d[i]) begin
      for (int b = 0; b < 8; b++) begin
        c = (c[0] ^ d[i][b]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
    end
    return ~c;
  endfunction

  task automatic take_bit(input logic b);
    if (b && ones < 7) ones++;
    if (!b && ones == 6) begin
      flags++;
      if (q.size() >= 3) begin
        got = q[0:$-2];
        crc_ok = (crc_of(got) === {q[$], q[$-1]});
        frames++;
      end
      q.delete();
      nb = 0;
    end else if (b && ones == 7) begin
      q.delete();
      nb = 0;
    end else if (b || ones != 5) begin
      sh = {b, sh[7:1]};
      nb++;
    end
    if (!b) ones = 0;
    if (nb == 8) begin
      q.push_back(sh);
      nb = 0;
    end
  endtask

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph = 0;
      lv = 1'b0;
      pl = 1'b0;
    end else begin
      ph = (tx_line !== lv) ? 0 : (ph + 1) % DIV;
      lv = tx_line;
      if (ph == DIV / 2) begin
        take_bit(tx_line === pl);
        pl = tx_line;
      end
    end
  end

  task automatic send_bit(input logic b);
    if (!b) lvl = ~lvl;
    rx_line <= lvl;
    repeat (DIV) @(posedge ref_clk);
  endtask

  task automatic send_byte(input logic [7:0] v, input logic stuff);
    for (int b = 0; b < 8; b++) begin
      send_bit(v[b]);
      run = (v[b] && stuff) ? run + 1 : 0;
      if (run == 5) begin
        send_bit(1'b0);
        run = 0;
      end
    end
  endtask

  task automatic send(input logic [7:0] d[$], input logic bad);
    logic [15:0] c;
    logic [7:0]  f[$];
    f = d;
    c = crc_of(d) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    send_byte(8'h7e, 1'b0);
    send_byte(8'h7e, 1'b0);
    foreach (f[i]) send_byte(f[i], 1'b1);
    send_byte(8'h7e, 1'b0);
    send_byte(8'h7e, 1'b0);
  endtask

  initial begin
    rx_line = 1'b0;
    lvl = 1'b0;
  end
endmodule

/* testbench/hnfc_codec_tb_top.sv */
/*
  self-checking bench for hnfc_codec: frames sent and received
  assumes hnfc_far_station models the remote station on the line
*/
`timescale 1ns/100ps
module hnfc_codec_tb_top;
  // ************
  // bench
  // ************
  localparam int BIT_DIV = 8;
  logic       ref_clk, rst, tx_key, tx_valid, tx_last, tx_ready, tx_line, rx_line;
  logic       rx_valid, rx_end, rx_good, rx_bad, seen_good, seen_bad;
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic [7:0] rx_q[$];
  int         ends = 0;
  int         cycles = 0;
  int         mismatches = 0;
  int         compares = 0;
  logic [7:0] fr[$] = '{8'h9c, 8'h94, 8'h6e, 8'h7e, 8'hff, 8'hfe, 8'he0, 8'h96, 8'h70,
                        8'h9a, 8'h9a, 8'hff, 8'h3f, 8'h61, 8'hee, 8'hf0, 8'h55};

  hnfc_codec #(.BIT_DIV(BIT_DIV)) u_hnfc_codec (.ref_clk, .rst, .tx_key, .tx_data,
    .tx_valid, .tx_last, .tx_ready, .tx_line, .rx_line, .rx_data, .rx_valid, .rx_end,
    .rx_good, .rx_bad);
  hnfc_far_station #(.DIV(BIT_DIV)) u_hnfc_far_station (.ref_clk, .rst, .tx_line, .rx_line);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    if (rx_end === 1'b1) begin
      ends++;
      seen_good = rx_good;
      seen_bad = rx_bad;
    end
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tx_case(input logic [7:0] d[$]);
    int f0;
    int n0;
    f0 = u_hnfc_far_station.frames;
    foreach (d[i]) begin
      tx_data  <= d[i];
      tx_valid <= 1'b1;
      tx_last  <= (i == d.size() - 1);
      do @(posedge ref_clk); while (tx_ready !== 1'b1);
    end
    tx_valid <= 1'b0;
    tx_last  <= 1'b0;
    for (int k = 0; k < 3000 && u_hnfc_far_station.frames == f0; k++) @(posedge ref_clk);
    chk("tx frames", 16'(f0 + 1), 16'(u_hnfc_far_station.frames));
    chk("tx check", 16'h0001, {15'h0000, u_hnfc_far_station.crc_ok});
    chk("tx length", 16'(d.size()), 16'(u_hnfc_far_station.got.size()));
    foreach (d[i]) chk("tx byte", {8'h00, d[i]}, {8'h00, u_hnfc_far_station.got[i]});
    n0 = u_hnfc_far_station.flags;
    repeat (20 * BIT_DIV) @(posedge ref_clk);
    chk("idle flags", 16'h0001, {15'h0000, u_hnfc_far_station.flags > n0 + 1});
  endtask

  task automatic rx_case(input logic [7:0] d[$], input logic bad, input logic good);
    int e0;
    e0 = ends;
    rx_q.delete();
    u_hnfc_far_station.send(d, bad);
    for (int k = 0; k < 200 && ends == e0; k++) @(posedge ref_clk);
    chk("rx end", 16'(e0 + 1), 16'(ends));
    chk("rx good", {15'h0000, good}, {15'h0000, seen_good});
    chk("rx bad", {15'h0000, !good}, {15'h0000, seen_bad});
    if (good) begin
      chk("rx length", 16'(d.size()), 16'(rx_q.size()));
      foreach (d[i]) chk("rx byte", {8'h00, d[i]}, {8'h00, rx_q[i]});
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    tx_key = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    tx_last = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    tx_key <= 1'b1;
    repeat (30 * BIT_DIV) @(posedge ref_clk);
    tx_case(fr);
    tx_case(fr[0:14]);
    tx_key <= 1'b0;
    rx_case(fr, 1'b0, 1'b1);
    rx_case(fr[0:14], 1'b0, 1'b1);
    rx_case(fr, 1'b1, 1'b0);
    rx_case(fr[0:13], 1'b0, 1'b0);
    final_report();
  end
endmodule
